// ### hw/sadfc_top.sv
// Frame control and serial read-out for a 16-bit converter.
// Assumes serial_clk, chip_sel_n and frame_sync come from a host; clk is the internal oscillator.
// Functional notes
// - Valid init cycle yields flag code next.
// - Frame sync may also bound init cycle.
// - Sample tracks input while selected, held at conversion start.
// - Conversion starts after 24th falling edge.
// - Conversion ends within 2.94 microseconds.
// - Aborted conversion yields flag code next.
// - Output word is previous sample's result.
// - Sixteen result bits, msb first.
// - Chip select fall starts cycle, msb ready.
// - Output advances on rising serial edge.
// - Frame sync rise starts cycle, shows msb.
// - Frame sync rise releases msb, fall samples; here only its rise is used, and the sample is held at conversion start.
// - Single-input variant: select fall shows msb.
// - Control edges accepted at any clock level.
// - Results are unipolar straight binary.
// - Auto power-down after conversion, wake on start.
// - Output released at 17th rising edge.
`timescale 1ns/10ps
module sadfc_top
   import sadfc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        clk_en,
   input  wire logic        serial_clk,
   input  wire logic        chip_sel_n,
   input  wire logic        frame_sync,
   input  wire logic [15:0] analog_input,
   output logic             serial_result_out,
   output logic             serial_result_oe_n,
   output logic             powered_down,
   output logic             converting,
   output logic             init_done
);
   typedef enum logic [2:0] {
      SADFC_IDLE = 3'b001,
      SADFC_CONV = 3'b010,
      SADFC_DOWN = 3'b100
   } sadfc_state_t;

   // Serial domain: a frame is open while select is low; frame sync does not gate it.
   logic        frame_act;
   logic [4:0]  fall_cnt_r;
   logic [4:0]  rise_cnt_r;
   logic        done_tgl_r;
   logic [4:0]  done_info_r;
   logic [15:0] word_r;

   assign frame_act = ~chip_sel_n;

   // Falling edges inside a frame are counted; the serial clock stops between frames,
   // so a deselect clears the count at once.
   always_ff @(negedge serial_clk or posedge sys_rst or posedge chip_sel_n) begin
      if (sys_rst || chip_sel_n) begin
         fall_cnt_r <= 5'h00;
      end else if (frame_act && fall_cnt_r != 5'h1f) begin
         fall_cnt_r <= fall_cnt_r + 5'h01;
      end
   end

   // Rising edges move the output to the next bit and release it after the last one.
   always_ff @(posedge serial_clk or posedge sys_rst or posedge chip_sel_n) begin
      if (sys_rst || chip_sel_n) begin
         rise_cnt_r <= 5'h00;
      end else if (rise_cnt_r != 5'h1f) begin
         rise_cnt_r <= rise_cnt_r + 5'h01;
      end
   end

   // Word handed from the core domain; an abort at frame start can change it while a frame is open.
   sadfc_xfer_if xw ();
   sadfc_xfer_if ev ();

   // Event toggle marking a select rise or a frame sync rise, with the falling-edge count at that edge.
   always_ff @(posedge chip_sel_n or posedge frame_sync or posedge sys_rst) begin
      if (sys_rst) begin
         done_tgl_r  <= 1'b0;
         done_info_r <= 5'h00;
      end else begin
         done_tgl_r  <= ~done_tgl_r;
         done_info_r <= fall_cnt_r;
      end
   end
   assign ev.tgl  = done_tgl_r;
   assign ev.info = done_info_r;
   assign xw.tgl  = 1'b0;
   assign xw.info = 5'h00;

   // Output bit: msb when select is low at the frame edge, then one bit per rising edge.
   // The first rising edge keeps the msb up for the first falling-edge capture.
   logic [4:0] bit_pos;
   logic [3:0] bit_idx;
   assign bit_pos = (rise_cnt_r == 5'h00) ? 5'(SADFC_WORD_BITS - 1) : 5'(SADFC_WORD_BITS) - rise_cnt_r;
   assign bit_idx = bit_pos[3:0];
   logic sdo_bit;
   logic sdo_hiz;
   assign sdo_bit = word_r[bit_idx];
   assign sdo_hiz = chip_sel_n | (rise_cnt_r >= SADFC_HIZ_RISE);

   // Core domain.
   logic ev_tgl_s;
   logic ev_tgl_d_r;
   logic cs_s;
   logic fs_s;
   logic fs_d_r;
   logic cs_d_r;
   logic sdo_s;
   logic hiz_s;
   sadfc_state_t state_r;
   logic [15:0] sample_r;
   logic        sampled_r;
   logic        init_r;
   logic        conv_start;
   logic        conv_abort;
   logic        conv_busy;
   logic        conv_done;
   logic [15:0] conv_res;
   logic        frame_start;

   sadfc_sync2 u_sync_ev  (.clk(clk), .sys_rst(sys_rst), .d(ev.tgl),    .q(ev_tgl_s));
   sadfc_sync2 u_sync_cs  (.clk(clk), .sys_rst(sys_rst), .d(chip_sel_n), .q(cs_s));
   sadfc_sync2 u_sync_fs  (.clk(clk), .sys_rst(sys_rst), .d(frame_sync), .q(fs_s));
   sadfc_sync2 u_sync_sdo (.clk(clk), .sys_rst(sys_rst), .d(sdo_bit),    .q(sdo_s));
   sadfc_sync2 u_sync_hz  (.clk(clk), .sys_rst(sys_rst), .d(sdo_hiz),    .q(hiz_s));

   // The result word is read by the serial side as a quasi-static bus: it only changes
   // at the end of a conversion, at an abort or at an init frame close, all settled before the first bit is taken.

   assign frame_start = (cs_d_r & ~cs_s) | (~fs_d_r & fs_s);
   assign conv_start  = clk_en && (ev_tgl_s != ev_tgl_d_r) && (ev.info >= SADFC_CONV_FALL) && !init_r;
   assign conv_abort  = clk_en && frame_start && conv_busy;

   sadfc_conv u_conv (
      .clk    (clk),
      .sys_rst(sys_rst),
      .ce     (clk_en),
      .start  (conv_start),
      .abort  (conv_abort),
      .sample (sample_r),
      .busy   (conv_busy),
      .done   (conv_done),
      .result (conv_res)
   );

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ev_tgl_d_r <= 1'b0;
         cs_d_r     <= 1'b1;
         fs_d_r     <= 1'b0;
      end else if (clk_en) begin
         ev_tgl_d_r <= ev_tgl_s;
         cs_d_r     <= cs_s;
         fs_d_r     <= fs_s;
      end
   end

   // Init cycle: the first frame after reset that closes after one to eight falling edges completes it.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         init_r <= 1'b1;
      end else if (clk_en && ev_tgl_s != ev_tgl_d_r && init_r) begin
         init_r <= (ev.info == 5'h00) || (ev.info > SADFC_INIT_MAX_FALL);
      end
   end

   // Sample tracks the input while select is low and is held from conversion start to the next frame start.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sample_r  <= SADFC_ZERO_CODE;
         sampled_r <= 1'b0;
      end else if (clk_en) begin
         if (frame_start) begin
            sampled_r <= 1'b0;
         end else if (!cs_s && !sampled_r && conv_busy == 1'b0) begin
            sample_r <= analog_input;
         end
         if (conv_start) begin
            sampled_r <= 1'b1;
         end
      end
   end

   // Result word for the next frame.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         word_r <= SADFC_FLAG_CODE;
      end else if (clk_en) begin
         if (conv_done) begin
            word_r <= conv_res;
         end else if (conv_abort) begin
            word_r <= SADFC_FLAG_CODE;
         end else if (ev_tgl_s != ev_tgl_d_r && init_r) begin
            word_r <= SADFC_FLAG_CODE;
         end
      end
   end

   // Power state.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_r <= SADFC_IDLE;
      end else if (clk_en) begin
         unique case (state_r)
            SADFC_IDLE: begin
               if (conv_start) begin
                  state_r <= SADFC_CONV;
               end
            end
            SADFC_CONV: begin
               if (conv_done) begin
                  state_r <= SADFC_DOWN;
               end else if (conv_abort) begin
                  state_r <= SADFC_IDLE;
               end
            end
            SADFC_DOWN: begin
               if (frame_start) begin
                  state_r <= SADFC_IDLE;
               end
            end
            default: state_r <= SADFC_IDLE;
         endcase
      end
   end

   // Registered outputs; the data pin is re-timed to clk.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         serial_result_out  <= 1'b0;
         serial_result_oe_n <= 1'b1;
         powered_down       <= 1'b0;
         converting         <= 1'b0;
         init_done          <= 1'b0;
      end else if (clk_en) begin
         serial_result_out  <= sdo_s;
         serial_result_oe_n <= hiz_s | cs_s;
         powered_down       <= (state_r == SADFC_DOWN);
         converting         <= conv_busy;
         init_done          <= ~init_r;
      end
   end
endmodule : sadfc_top

// ### inc/sadfc_pkg.sv
// Constants shared by the serial converter frame control block.
// Assumes a 250 MHz system clock and a separate serial clock domain.
package sadfc_pkg;
   localparam int          SADFC_WORD_BITS     = 16;
   localparam logic [15:0] SADFC_FLAG_CODE     = 16'hff00;
   localparam logic [15:0] SADFC_ZERO_CODE     = 16'h0000;
   localparam logic [15:0] SADFC_FULL_CODE     = 16'hffff;
   localparam logic [4:0]  SADFC_INIT_MAX_FALL = 5'h08;
   localparam logic [4:0]  SADFC_SAMPLE_FIRST  = 5'h05;
   localparam logic [4:0]  SADFC_SAMPLE_LEN    = 5'h14;
   localparam logic [4:0]  SADFC_CONV_FALL     = 5'h18;
   localparam logic [4:0]  SADFC_HIZ_RISE      = 5'h11;
   localparam int          SADFC_CLK_MHZ       = 250;
   localparam int          SADFC_CONV_NS_X100  = 294000;
   localparam int          SADFC_CONV_CYC      = (SADFC_CONV_NS_X100 / 100) * SADFC_CLK_MHZ / 1000;
   localparam logic [9:0]  SADFC_CONV_CYC_W    = 10'(SADFC_CONV_CYC);
endpackage : sadfc_pkg

// ### inc/sadfc_xfer_if.sv
// Carries a frame event and its data from the serial domain to the core.
// Assumes the producer holds data stable while a toggle is pending.
`timescale 1ns/10ps
interface sadfc_xfer_if;
   logic        tgl;
   logic [4:0]  info;
   modport src (output tgl, output info);
   modport dst (input tgl, input info);
endinterface : sadfc_xfer_if

// ### hw/sadfc_sync2.sv
// Two flip-flop level synchroniser.
// Assumes the input is quasi-static relative to clk.
`timescale 1ns/10ps
module sadfc_sync2 (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic d,
   output logic      q
);
   logic meta_r;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_r <= 1'b0;
         q      <= 1'b0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : sadfc_sync2

// ### hw/sadfc_conv.sv
// Conversion timer on the internal oscillator, standing in for the converter core.
// Assumes start is a one-cycle pulse on clk.
`timescale 1ns/10ps
module sadfc_conv
   import sadfc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        ce,
   input  wire logic        start,
   input  wire logic        abort,
   input  wire logic [15:0] sample,
   output logic             busy,
   output logic             done,
   output logic [15:0]      result
);
   logic [9:0] cnt_r;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_r  <= 10'h000;
         busy   <= 1'b0;
         done   <= 1'b0;
         result <= SADFC_ZERO_CODE;
      end else if (ce) begin
         done <= 1'b0;
         if (abort) begin
            busy <= 1'b0;
         end else if (start) begin
            busy  <= 1'b1;
            cnt_r <= SADFC_CONV_CYC_W - 10'h001;
         end else if (busy) begin
            if (cnt_r == 10'h000) begin
               busy   <= 1'b0;
               done   <= 1'b1;
               result <= sample;
            end else begin
               cnt_r <= cnt_r - 10'h001;
            end
         end
      end
   end
endmodule : sadfc_conv

// ### verif/sadfc_top_sva.sv
// Port-level checker for the converter frame control top module.
// Assumes clk and sys_rst of the core domain; bound by the statement below.
`timescale 1ns/10ps
module sadfc_top_sva (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        serial_clk,
   input wire logic        chip_sel_n,
   input wire logic        frame_sync,
   input wire logic        serial_result_out,
   input wire logic        serial_result_oe_n,
   input wire logic        powered_down,
   input wire logic        converting,
   input wire logic        init_done
);
   localparam int CONV_MAX = 740;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   a_oe_idle: assert property ((chip_sel_n && frame_sync) [*8] |-> serial_result_oe_n)
      else $error("output driven while idle");
   a_drive_on_sel: assert property ($fell(chip_sel_n) && frame_sync |-> ##[1:8] !serial_result_oe_n)
      else $error("msb not driven after select");
   a_release_desel: assert property ($rose(chip_sel_n) |-> ##[1:8] serial_result_oe_n)
      else $error("output not released on deselect");
   a_conv_bound: assert property ($rose(converting) |-> ##[1:CONV_MAX] !converting)
      else $error("conversion too long");
   a_pd_after_conv: assert property ($fell(converting) && chip_sel_n |-> ##[0:4] powered_down)
      else $error("no power down after conversion");
   a_wake_sel: assert property ($fell(chip_sel_n) |-> ##[1:8] !powered_down)
      else $error("no wake on select");
   a_pd_exclusive: assert property (!(converting && powered_down))
      else $error("converting while powered down");
   a_init_sticky: assert property (init_done |=> init_done)
      else $error("init flag lost");
   a_data_hold: assert property ((!serial_clk && !chip_sel_n && $stable(frame_sync)) [*7]
      |-> $stable(serial_result_out))
      else $error("data moved without serial rise");
endmodule : sadfc_top_sva

bind sadfc_top sadfc_top_sva u_sva (.clk(clk), .sys_rst(sys_rst), .serial_clk(serial_clk),
   .chip_sel_n(chip_sel_n), .frame_sync(frame_sync), .serial_result_out(serial_result_out),
   .serial_result_oe_n(serial_result_oe_n), .powered_down(powered_down), .converting(converting),
   .init_done(init_done));

// ### verif/sadfc_host_model.sv
// Host serial port model: clock polarity 0, capture on falling edges.
// Assumes lclk is a free 15 ns clock; the serial clock only runs inside frames.
`timescale 1ns/10ps
module sadfc_host_model (
   input  wire logic lclk,
   input  wire logic serial_result_out,
   output logic      serial_clk,
   output logic      chip_sel_n,
   output logic      frame_sync
);
   initial begin
      serial_clk = 1'b0;
      chip_sel_n = 1'b1;
      frame_sync = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge lclk);
   endtask : tick
   // Runs a frame of n falling edges; fs selects sync-pulse framing with select low.
   task automatic frame(input int n, input bit fs, output logic [15:0] word);
      int i;
      word = 16'h0000;
      @(posedge lclk);
      if (fs) begin
         frame_sync <= 1'b0;
         tick(2);
         chip_sel_n <= 1'b0;
         tick(2);
         frame_sync <= 1'b1;
         tick(2);
         frame_sync <= 1'b0;
      end else begin
         frame_sync <= 1'b1;
         tick(2);
         chip_sel_n <= 1'b0;
      end
      tick(2);
      for (i = 1; i <= n; i++) begin
         serial_clk <= 1'b1;
         tick(2);
         if (i <= 16) word[16 - i] = serial_result_out;
         serial_clk <= 1'b0;
         tick(2);
      end
      chip_sel_n <= 1'b1;
      tick(4);
   endtask : frame
endmodule : sadfc_host_model

// ### verif/tb_serial_adc_frame_control.sv
// Self-checking bench for the converter frame control top module.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/10ps
module tb_serial_adc_frame_control;
   import sadfc_pkg::*;
   logic        clk = 1'b0;
   logic        lclk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        clk_en = 1'b1;
   logic [15:0] analog_input = 16'h0000;
   logic        serial_clk, chip_sel_n, frame_sync, serial_result_out;
   logic        serial_result_oe_n, powered_down, converting, init_done;
   logic [15:0] word, prev, a;
   int          n_fail = 0;
   int          cmp_count = 0;
   always #2 clk = ~clk;
   always #7.5 lclk = ~lclk;
   sadfc_top uut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .serial_clk(serial_clk),
      .chip_sel_n(chip_sel_n), .frame_sync(frame_sync), .analog_input(analog_input),
      .serial_result_out(serial_result_out), .serial_result_oe_n(serial_result_oe_n),
      .powered_down(powered_down), .converting(converting), .init_done(init_done));
   sadfc_host_model host (.lclk(lclk), .serial_result_out(serial_result_out), .serial_clk(serial_clk),
      .chip_sel_n(chip_sel_n), .frame_sync(frame_sync));
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic wait_pd();
      int i;
      for (i = 0; i < 2000 && powered_down !== 1'b1; i++) @(posedge clk);
      check("powered_down", 16'h0001, {15'h0, powered_down});
   endtask : wait_pd
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   initial begin
      #300000;
      n_fail++;
      $display("unexpected watchdog expected finish seen hang");
      tally_and_finish();
   end
   initial begin
      int k;
      a = $urandom(32'h9a1d1b94);
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge clk);
      host.frame(1 + $urandom % 8, 1'b0, word);
      repeat (10) @(posedge clk);
      check("init_done", 16'h0001, {15'h0, init_done});
      $display("test init done");
      prev = SADFC_FLAG_CODE;
      for (k = 0; k < 10; k++) begin
         a = (k == 0) ? SADFC_ZERO_CODE : (k == 1) ? SADFC_FULL_CODE : 16'($urandom);
         @(posedge clk);
         analog_input <= a;
         host.frame(24, k % 3 == 2, word);
         check("word", prev, word);
         prev = a;
         wait_pd();
      end
      $display("test stream done");
      host.frame(24, 1'b0, word);
      check("word", prev, word);
      host.frame(24, 1'b0, word);
      check("aborted word", SADFC_FLAG_CODE, word);
      wait_pd();
      host.frame(24, 1'b0, word);
      check("word after abort", prev, word);
      wait_pd();
      $display("test abort done");
      tally_and_finish();
   end
endmodule : tb_serial_adc_frame_control
